// >>> pwm_pkg.sv
// Package for the PWM period/duty generator: register map, field layouts,
// reset values, output modes and generator states.
// Assumes a 32-bit APB register bus with byte addresses and 8-bit registers.
package pwm_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_DUTY_HI   = 8'h04;
  localparam logic [7:0] OFF_PERIOD    = 8'h08;
  localparam logic [7:0] OFF_COUNT     = 8'h0C;
  localparam logic [7:0] OFF_TCFG      = 8'h10;
  localparam logic [7:0] OFF_DUTY_WORK = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  localparam logic [7:0] OFF_RELOC     = 8'h1C;
  localparam logic [7:0] OFF_SHUTDN    = 8'h20;
  localparam logic [7:0] OFF_STEER     = 8'h24;
  localparam logic [7:0] OFF_DEADBAND  = 8'h28;
  localparam logic [7:0] OFF_PINDIR    = 8'h2C;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] DUTY_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] TCFG_RST   = 8'h00;
  localparam logic [7:0] STEER_RST  = 8'h01;
  localparam logic [7:0] ZERO8      = 8'h00;
  localparam logic [3:0] PINDIR_RST = 4'hF;

  // ==========================================================================
  // Field positions and codes
  localparam int         STAT_FLAG_BIT = 0;
  localparam int         STAT_RUN_BIT  = 1;
  localparam int         STAT_SLEEP_BIT = 2;
  localparam int         RELOC_THIRD_BIT  = 0;
  localparam int         RELOC_FOURTH_BIT = 1;
  localparam logic [1:0] FUNC_PWM     = 2'h3;
  localparam logic [1:0] PS_DIV1      = 2'h0;
  localparam logic [1:0] PS_DIV4      = 2'h1;
  localparam logic [5:0] LAST_DIV1    = 6'h03;
  localparam logic [5:0] LAST_DIV4    = 6'h0F;
  localparam logic [5:0] LAST_DIV16   = 6'h3F;
  localparam logic [3:0] OWN_HALF     = 4'h3;
  localparam logic [3:0] OWN_FULL     = 4'hF;

  // Output mode field encodings.
  typedef enum logic [1:0] {
    MODE_SINGLE   = 2'b00,
    MODE_FULL_FWD = 2'b01,
    MODE_HALF     = 2'b10,
    MODE_FULL_REV = 2'b11
  } mode_t;

  // Generator start-up states.
  typedef enum logic [1:0] {
    GEN_OFF   = 2'b00,
    GEN_ARMED = 2'b01,
    GEN_RUN   = 2'b10
  } gen_state_t;

  // Control register layout.
  typedef struct packed {
    mode_t      output_mode_field;
    logic [1:0] duty_low_bits;
    logic [3:0] function_select_field;
  } ctrl_t;

  // Timer configuration register layout.
  typedef struct packed {
    logic       spare;
    logic [3:0] postscale_field;
    logic       timer_run_bit;
    logic [1:0] prescale_field;
  } tcfg_t;

endpackage

// >>> pwm_period_duty_generator.sv
// Enhanced PWM generator with its own 8-bit period timer, prescaler,
// postscaled match flag, double-buffered 10-bit duty and four output pins.
// Assumes an APB master on pclk and an asynchronous sleep request pin.
//
// Notes on behaviour
// - In sleep the timer and module state freeze; pins keep their level.
// - After sleep the timer resumes from its held count.
// - The time base runs from the system clock, so frequency scales with it.
// - Reset makes all pins inputs and loads register reset values.
// - Prescaler offers divide by 1, 4 and 16 only.
// - Third and fourth outputs can move to alternate pins.
// - Enhanced mode drives up to four pins with ten-bit duty.
// - Four output modes chosen by the output mode field.
// - Pin polarity chosen by the function select field.
// - Writing zero to the control register releases all pins.
// - After enabling, output waits for a new period to begin.
// - Pins unused by the mode stay free for other functions.
// - Shutdown, restart, dead-band and steering registers exist.
// - Period match clears timer, sets output unless duty is zero, latches buffered duty.
// - Ten-bit duty: high byte plus two control bits, used next period.
// - Output clears when ten-bit time base equals latched duty.
module pwm_period_duty_generator (
  input  wire logic        pclk,         // System clock.
  input  wire logic        presetn,      // Asynchronous reset, active low.
  input  wire logic [7:0]  paddr,        // APB byte address.
  input  wire logic        psel,         // APB select.
  input  wire logic        penable,      // APB access phase.
  input  wire logic        pwrite,       // APB direction, high for write.
  input  wire logic [31:0] pwdata,       // APB write data.
  input  wire logic [3:0]  pstrb,        // APB byte strobes.
  output logic      [31:0] prdata,       // APB read data.
  output logic             pready,       // APB ready.
  output logic             pslverr,      // APB error on unmapped address.
  input  wire logic        sleep_req,    // Device sleep request pin.
  output logic      [3:0]  pin_out,      // First..fourth output levels.
  output logic      [3:0]  pin_oe,       // First..fourth output enables.
  output logic      [1:0]  alt_out,      // Alternate third, fourth levels.
  output logic      [1:0]  alt_oe        // Alternate third, fourth enables.
);

  // ==========================================================================
  // Register state
  // Bus-visible registers come first, internal timing state after them.
  pwm_pkg::ctrl_t     ctrl_r;
  pwm_pkg::tcfg_t     tcfg_r;
  logic [7:0]         duty_hi_r;
  logic [7:0]         period_r;
  logic [7:0]         count_r;
  logic [7:0]         reloc_r;
  logic [7:0]         shutdn_r;
  logic [7:0]         steer_r;
  logic [7:0]         deadband_r;
  logic [3:0]         pindir_r;
  logic [9:0]         duty_work_r;
  logic               flag_r;
  logic [3:0]         post_r;
  logic [5:0]         presc_r;
  logic               pwm_q_r;
  pwm_pkg::gen_state_t gen_r;
  logic               sleep_meta_r;
  logic               sleep_r;
  logic [31:0]        prdata_r;
  logic               pready_r;
  logic               pslverr_r;
  logic [3:0]         pin_out_r;
  logic [3:0]         pin_oe_r;
  logic [1:0]         alt_out_r;
  logic [1:0]         alt_oe_r;

  // ==========================================================================
  // Sleep request synchroniser
  // The pin is asynchronous, so only the second flop is used by logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_meta_r <= 1'b0;
      sleep_r      <= 1'b0;
    end else begin
      sleep_meta_r <= sleep_req;
      sleep_r      <= sleep_meta_r;
    end
  end

  // ==========================================================================
  // APB slave
  logic       access;
  logic       wr_en;
  logic       mapped;
  logic [7:0] wbyte;

  // A write takes effect at the edge where pready is seen high.
  assign access = psel & penable;
  assign wr_en  = access & pwrite & pready_r & pstrb[0];
  assign wbyte  = pwdata[7:0];

  // Address decode for the mapped words.
  always_comb begin
    case (paddr)
      pwm_pkg::OFF_CTRL, pwm_pkg::OFF_DUTY_HI, pwm_pkg::OFF_PERIOD,
      pwm_pkg::OFF_COUNT, pwm_pkg::OFF_TCFG, pwm_pkg::OFF_DUTY_WORK,
      pwm_pkg::OFF_STATUS, pwm_pkg::OFF_RELOC, pwm_pkg::OFF_SHUTDN,
      pwm_pkg::OFF_STEER, pwm_pkg::OFF_DEADBAND,
      pwm_pkg::OFF_PINDIR: mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end

  // One wait state: data and ready are registered so outputs come from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~mapped;
      prdata_r  <= 32'h0000_0000;
      if (access && !pready_r && !pwrite) begin
        case (paddr)
          pwm_pkg::OFF_CTRL:      prdata_r[7:0] <= ctrl_r;
          pwm_pkg::OFF_DUTY_HI:   prdata_r[7:0] <= duty_hi_r;
          pwm_pkg::OFF_PERIOD:    prdata_r[7:0] <= period_r;
          pwm_pkg::OFF_COUNT:     prdata_r[7:0] <= count_r;
          pwm_pkg::OFF_TCFG:      prdata_r[7:0] <= tcfg_r;
          pwm_pkg::OFF_DUTY_WORK: prdata_r[9:0] <= duty_work_r;
          pwm_pkg::OFF_STATUS: begin
            prdata_r[pwm_pkg::STAT_FLAG_BIT]  <= flag_r;
            prdata_r[pwm_pkg::STAT_RUN_BIT]   <= (gen_r == pwm_pkg::GEN_RUN);
            prdata_r[pwm_pkg::STAT_SLEEP_BIT] <= sleep_r;
          end
          pwm_pkg::OFF_RELOC:     prdata_r[7:0] <= reloc_r;
          pwm_pkg::OFF_SHUTDN:    prdata_r[7:0] <= shutdn_r;
          pwm_pkg::OFF_STEER:     prdata_r[7:0] <= steer_r;
          pwm_pkg::OFF_DEADBAND:  prdata_r[7:0] <= deadband_r;
          pwm_pkg::OFF_PINDIR:    prdata_r[3:0] <= pindir_r;
          default:                prdata_r      <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ==========================================================================
  // Software-only configuration registers
  // Shutdown, restart, dead-band and steering settings are held here; only
  // steering acts on the pins in this block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= pwm_pkg::ctrl_t'(pwm_pkg::CTRL_RST);
      duty_hi_r  <= pwm_pkg::DUTY_RST;
      period_r   <= pwm_pkg::PERIOD_RST;
      tcfg_r     <= pwm_pkg::tcfg_t'(pwm_pkg::TCFG_RST);
      reloc_r    <= pwm_pkg::ZERO8;
      shutdn_r   <= pwm_pkg::ZERO8;
      steer_r    <= pwm_pkg::STEER_RST;
      deadband_r <= pwm_pkg::ZERO8;
      pindir_r   <= pwm_pkg::PINDIR_RST;
    end else if (wr_en) begin
      case (paddr)
        pwm_pkg::OFF_CTRL:     ctrl_r     <= pwm_pkg::ctrl_t'(wbyte);
        pwm_pkg::OFF_DUTY_HI:  duty_hi_r  <= wbyte;
        pwm_pkg::OFF_PERIOD:   period_r   <= wbyte;
        pwm_pkg::OFF_TCFG:     tcfg_r     <= pwm_pkg::tcfg_t'(wbyte);
        pwm_pkg::OFF_RELOC:    reloc_r    <= wbyte;
        pwm_pkg::OFF_SHUTDN:   shutdn_r   <= wbyte;
        pwm_pkg::OFF_STEER:    steer_r    <= wbyte;
        pwm_pkg::OFF_DEADBAND: deadband_r <= wbyte;
        pwm_pkg::OFF_PINDIR:   pindir_r   <= wbyte[3:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Prescaler and time base
  logic [5:0] last;
  logic [1:0] low2;
  logic       tick;
  logic       period_end;
  logic       pwm_mode;
  logic [9:0] duty_buf;
  // Step strobe and look-ahead value of the ten-bit time base.
  logic       step;
  logic       advance;
  logic [9:0] tb_next;

  // Only three divide ratios exist; both upper codes mean divide by 16.
  always_comb begin
    case (tcfg_r.prescale_field)
      pwm_pkg::PS_DIV1: begin
        last = pwm_pkg::LAST_DIV1;
        low2 = presc_r[1:0];
        step = 1'b1;
      end
      pwm_pkg::PS_DIV4: begin
        last = pwm_pkg::LAST_DIV4;
        low2 = presc_r[3:2];
        step = (presc_r[1:0] == 2'b11);
      end
      default: begin
        last = pwm_pkg::LAST_DIV16;
        low2 = presc_r[5:4];
        step = (presc_r[3:0] == 4'hF);
      end
    endcase
  end

  // The timer advances once per four system clocks times the ratio.
  assign tick       = tcfg_r.timer_run_bit & ~sleep_r & (presc_r == last);
  assign period_end = tick & (count_r == period_r);
  assign pwm_mode   = (ctrl_r.function_select_field[3:2] == pwm_pkg::FUNC_PWM);
  assign duty_buf   = {duty_hi_r, ctrl_r.duty_low_bits};
  // The step strobe marks the clock on which the time base low bits move on.
  // The duty compare looks one step ahead, so the registered level falls
  // on the very edge where the time base reaches the duty value.
  assign advance    = tcfg_r.timer_run_bit & ~sleep_r & step;
  assign tb_next    = {count_r, low2} + 10'h001;

  // Prescaler counts system clocks and holds in sleep or when stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 6'h00;
    end else if (tcfg_r.timer_run_bit && !sleep_r) begin
      presc_r <= tick ? 6'h00 : presc_r + 6'h01;
    end
  end

  // Period timer: a bus write wins over counting; the count is held in
  // sleep so it resumes where it stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= pwm_pkg::ZERO8;
    end else if (wr_en && paddr == pwm_pkg::OFF_COUNT) begin
      count_r <= wbyte;
    end else if (period_end) begin
      count_r <= pwm_pkg::ZERO8;
    end else if (tick) begin
      count_r <= count_r + 8'h01;
    end
  end

  // Postscaled match flag; a hardware set in the same cycle as a clear wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_r <= 4'h0;
      flag_r <= 1'b0;
    end else begin
      if (period_end) begin
        post_r <= (post_r == tcfg_r.postscale_field) ? 4'h0 : post_r + 4'h1;
      end
      if (period_end && post_r == tcfg_r.postscale_field) begin
        flag_r <= 1'b1;
      end else if (wr_en && paddr == pwm_pkg::OFF_STATUS && wbyte[pwm_pkg::STAT_FLAG_BIT]) begin
        flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Duty latch and modulated level
  // Double buffering keeps the waveform glitch free while software writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_work_r <= 10'h000;
      pwm_q_r     <= 1'b0;
    end else if (period_end) begin
      duty_work_r <= duty_buf;
      pwm_q_r     <= (duty_buf != 10'h000);
    end else if (advance && tb_next == duty_work_r) begin
      // Comparing the present value instead would stretch each pulse by a clock.
      pwm_q_r     <= 1'b0;
    end
  end

  // Start-up: arm on entering PWM, run only from the next period start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_r <= pwm_pkg::GEN_OFF;
    end else if (!pwm_mode) begin
      gen_r <= pwm_pkg::GEN_OFF;
    end else begin
      case (gen_r)
        pwm_pkg::GEN_OFF:   gen_r <= pwm_pkg::GEN_ARMED;
        pwm_pkg::GEN_ARMED: if (period_end) begin
          gen_r <= pwm_pkg::GEN_RUN;
        end
        pwm_pkg::GEN_RUN:   gen_r <= pwm_pkg::GEN_RUN;
        default:            gen_r <= pwm_pkg::GEN_OFF;
      endcase
    end
  end

  // ==========================================================================
  // Output steering, polarity and pin ownership
  logic       running;
  logic       act_ac;
  logic       act_bd;
  logic [3:0] raw;
  logic [3:0] own;
  logic [3:0] lvl;
  logic       reloc_c;
  logic       reloc_d;

  assign running = (gen_r == pwm_pkg::GEN_RUN);
  assign act_ac  = ~ctrl_r.function_select_field[1];
  assign act_bd  = ~ctrl_r.function_select_field[0];
  assign reloc_c = reloc_r[pwm_pkg::RELOC_THIRD_BIT];
  assign reloc_d = reloc_r[pwm_pkg::RELOC_FOURTH_BIT];

  // Active-high levels per mode; before the first period all are inactive.
  always_comb begin
    raw = 4'h0;
    own = 4'h0;
    case (ctrl_r.output_mode_field)
      pwm_pkg::MODE_SINGLE: begin
        raw = {4{running & pwm_q_r}};
        own = steer_r[3:0];
      end
      pwm_pkg::MODE_HALF: begin
        raw = {2'b00, running & ~pwm_q_r, running & pwm_q_r};
        own = pwm_pkg::OWN_HALF;
      end
      pwm_pkg::MODE_FULL_FWD: begin
        raw = {running & pwm_q_r, 2'b00, running};
        own = pwm_pkg::OWN_FULL;
      end
      pwm_pkg::MODE_FULL_REV: begin
        raw = {1'b0, running, running & pwm_q_r, 1'b0};
        own = pwm_pkg::OWN_FULL;
      end
      default: begin
        raw = 4'h0;
        own = 4'h0;
      end
    endcase
    // A cleared control register or another function owns no pin.
    if (!pwm_mode) begin
      own = 4'h0;
    end
  end

  // Inactive level is the opposite of the active level of each pair.
  assign lvl = {raw[3] ^ ~act_bd, raw[2] ^ ~act_ac, raw[1] ^ ~act_bd, raw[0] ^ ~act_ac};

  // Pins are registered and frozen during sleep, so each keeps its level.
  // A pin drives only while owned and its direction bit is cleared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= 4'h0;
      pin_oe_r  <= 4'h0;
      alt_out_r <= 2'h0;
      alt_oe_r  <= 2'h0;
    end else if (!sleep_r) begin
      pin_out_r <= lvl;
      pin_oe_r  <= own & ~pindir_r & {~reloc_d, ~reloc_c, 2'b11};
      alt_out_r <= lvl[3:2];
      alt_oe_r  <= own[3:2] & ~pindir_r[3:2] & {reloc_d, reloc_c};
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe  = pin_oe_r;
  assign alt_out = alt_out_r;
  assign alt_oe  = alt_oe_r;

endmodule

// >>> pwm_period_duty_checker.sv
// Checker for the PWM generator: bus answer timing and pin ownership.
// Assumes a bind to the generator's top module; it sees only its ports.
module pwm_period_duty_checker (
  input wire logic        pclk,      // Clock.
  input wire logic        presetn,   // Reset, active low.
  input wire logic [7:0]  paddr,     // Address.
  input wire logic        psel,      // Select.
  input wire logic        penable,   // Access phase.
  input wire logic        pwrite,    // Direction.
  input wire logic [31:0] pwdata,    // Write data.
  input wire logic [3:0]  pstrb,     // Strobes.
  input wire logic [31:0] prdata,    // Read data.
  input wire logic        pready,    // Ready.
  input wire logic        pslverr,   // Error.
  input wire logic        sleep_req, // Sleep request.
  input wire logic [3:0]  pin_out,   // Pin levels.
  input wire logic [3:0]  pin_oe,    // Pin enables.
  input wire logic [1:0]  alt_out,   // Alternate levels.
  input wire logic [1:0]  alt_oe     // Alternate enables.
);
  // ==========================================================================
  // Clocking and sequences
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // First access cycle, before the answer.
  sequence access_first;
    psel && penable && !pready;
  endsequence

  // Completed write of zero to the control register while awake.
  sequence ctrl_cleared;
    psel && penable && pready && pwrite && pstrb[0] && !sleep_req &&
      paddr == pwm_pkg::OFF_CTRL && pwdata[7:0] == 8'h00;
  endsequence

  // ==========================================================================
  // Assertions
  a_ready_one_wait: assert property (access_first |=> pready)
    else $error("ready missing after the first access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready stood for more than one cycle");
  a_error_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error raised outside an answer");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero between answers");
  a_reset_pins_input:
    assert property ($rose(presetn) |-> pin_oe == 4'h0 && alt_oe == 2'h0)
    else $error("pins driven right after reset");
  // Six samples leave room for the two-flop sleep synchroniser and the pin stage.
  a_sleep_holds_pins:
    assert property (sleep_req [*6] |-> $stable(pin_out) && $stable(pin_oe))
    else $error("pins moved while asleep");
  a_zero_releases_pins:
    assert property (ctrl_cleared |=> ##[0:2] (pin_oe == 4'h0 && alt_oe == 2'h0))
    else $error("pins still driven after control cleared");
  a_reloc_one_place:
    assert property (!(alt_oe[0] && pin_oe[2]) && !(alt_oe[1] && pin_oe[3]))
    else $error("output driven at both locations");
endmodule

bind pwm_period_duty_generator pwm_period_duty_checker i_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_req(sleep_req), .pin_out(pin_out), .pin_oe(pin_oe),
  .alt_out(alt_out), .alt_oe(alt_oe)
);

// >>> pwm_load_model.sv
// Load model: the bridge drivers that sit on the generator's pins.
// Assumes the pin levels and enables of the generator as inputs.
module pwm_load_model (
  input  wire logic       pclk,    // Clock.
  input  wire logic       presetn, // Reset, active low.
  input  wire logic [3:0] pin_out, // Driven levels.
  input  wire logic [3:0] pin_oe,  // Enables.
  input  wire logic [1:0] alt_out, // Alternate levels.
  input  wire logic [1:0] alt_oe,  // Alternate enables.
  output logic      [3:0] pin_lvl, // Wire levels.
  output logic      [1:0] alt_lvl  // Alternate wire levels.
);
  logic [5:0] last_r;

  // An undriven line flips every cycle, so a stale level never passes for a driven one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= 6'h00;
    end else begin
      last_r <= {alt_lvl, pin_lvl};
    end
  end

  // Driven lines follow the generator.
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ~last_r[3:0]);
  assign alt_lvl = (alt_oe & alt_out) | (~alt_oe & ~last_r[5:4]);
endmodule

// >>> pwm_period_duty_generator_test.sv
// Testbench for the PWM generator: registers, timing, modes and sleep.
// Assumes the generator, its package, the checker and the load model.
module pwm_period_duty_generator_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, pin_out, pin_oe, pin_lvl;
  logic [1:0]  alt_out, alt_oe, alt_lvl;
  int          miscompares, checks, hi, per, n;
  localparam logic [7:0] rst_addr [11] = '{pwm_pkg::OFF_CTRL, pwm_pkg::OFF_DUTY_HI,
    pwm_pkg::OFF_PERIOD, pwm_pkg::OFF_COUNT, pwm_pkg::OFF_TCFG, pwm_pkg::OFF_DUTY_WORK,
    pwm_pkg::OFF_RELOC, pwm_pkg::OFF_SHUTDN, pwm_pkg::OFF_STEER, pwm_pkg::OFF_DEADBAND,
    pwm_pkg::OFF_PINDIR};
  localparam logic [7:0] rst_val [11] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h00, 8'h0F};
  localparam logic [7:0] mode_ctrl [5] = '{8'h2C, 8'h6C, 8'hAC, 8'hEC, 8'h6E};
  localparam int         mode_pin [5]  = '{0, 3, 0, 1, 3};
  localparam logic [3:0] mode_own [5]  = '{4'hF, 4'hF, 4'h3, 4'hF, 4'hF};
  localparam logic [3:0] mode_snap [5] = '{4'hF, 4'h9, 4'h1, 4'h6, 4'hC};

  pwm_period_duty_generator i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
    .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe));
  pwm_load_model i_load (.pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe(pin_oe),
    .alt_out(alt_out), .alt_oe(alt_oe), .pin_lvl(pin_lvl), .alt_lvl(alt_lvl));

  // ==========================================================================
  // Clock, comparison and bus tasks
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One transfer; an idle edge follows so the next setup never lands in the same step.
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 16) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask

  // Counts edges while a pin holds level v; the bound cuts a stuck pin short.
  task automatic run_for(input int b, input logic v, output int cnt);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (pin_lvl[b] === v && cnt < 3000);
    if (cnt >= 3000) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  task automatic measure(input int b, input bit skip, output int h, output int p);
    int lo;
    if (skip) begin
      run_for(b, 1'b1, lo);
    end
    run_for(b, 1'b0, lo);
    run_for(b, 1'b1, h);
    run_for(b, 1'b0, lo);
    p = h + lo;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    int          sh;
    miscompares = 0;
    checks      = 0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    pstrb       = 4'h1;
    sleep_req   = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, storage, read-only and unmapped places.
    check({28'h0, pin_oe}, 32'h0);
    for (int i = 0; i < 11; i++) begin
      rd_chk(rst_addr[i], {24'h0, rst_val[i]});
    end
    wr(pwm_pkg::OFF_SHUTDN, 8'h5A);
    rd_chk(pwm_pkg::OFF_SHUTDN, 32'h5A);
    wr(pwm_pkg::OFF_DUTY_WORK, 8'hFF);
    rd_chk(pwm_pkg::OFF_DUTY_WORK, 32'h0);
    apb(1'b0, 8'h30, 8'h00, q);
    check({31'h0, last_err}, 32'h1);
    $display("Register test done");
    // Every prescaler code: whole first pulse, period scaled by the ratio.
    wr(pwm_pkg::OFF_PINDIR, 8'h00);
    wr(pwm_pkg::OFF_PERIOD, 8'h03);
    wr(pwm_pkg::OFF_DUTY_HI, 8'h01);
    for (int ps = 0; ps < 4; ps++) begin
      sh = (ps == 3) ? 4 : 2 * ps;
      wr(pwm_pkg::OFF_TCFG, 8'h04 | 8'(ps));
      wr(pwm_pkg::OFF_CTRL, 8'h2C);
      measure(0, 1'b0, hi, per);
      check(32'(hi), 32'(6 << sh));
      check(32'(per), 32'(16 << sh));
      wr(pwm_pkg::OFF_CTRL, 8'h00);
    end
    $display("Prescaler test done");
    // A duty written mid-period waits for the period end; zero duty stays low.
    wr(pwm_pkg::OFF_TCFG, 8'h06);
    wr(pwm_pkg::OFF_CTRL, 8'h2C);
    run_for(0, 1'b0, n);
    wr(pwm_pkg::OFF_DUTY_HI, 8'h02);
    rd_chk(pwm_pkg::OFF_DUTY_WORK, 32'h6);
    run_for(0, 1'b1, n);
    run_for(0, 1'b0, n);
    run_for(0, 1'b1, hi);
    check(32'(hi), 32'hA0);
    rd_chk(pwm_pkg::OFF_DUTY_WORK, 32'hA);
    wr(pwm_pkg::OFF_DUTY_HI, 8'h00);
    wr(pwm_pkg::OFF_CTRL, 8'h0C);
    repeat (600) @(posedge pclk);
    n = 0;
    repeat (600) begin
      @(posedge pclk);
      n += int'(pin_lvl[0] === 1'b1);
    end
    check(32'(n), 32'h0);
    $display("Duty test done");
    // Every output mode, one polarity choice, then relocation.
    wr(pwm_pkg::OFF_TCFG, 8'h04);
    wr(pwm_pkg::OFF_DUTY_HI, 8'h01);
    wr(pwm_pkg::OFF_STEER, 8'h0F);
    for (int i = 0; i < 5; i++) begin
      wr(pwm_pkg::OFF_CTRL, mode_ctrl[i]);
      repeat (2) measure(mode_pin[i], 1'b1, hi, per);
      check({28'h0, pin_oe}, {28'h0, mode_own[i]});
      check({28'h0, pin_lvl & pin_oe}, {28'h0, mode_snap[i]});
      check(32'(hi), 32'h6);
    end
    wr(pwm_pkg::OFF_RELOC, 8'h03);
    @(posedge pclk);
    check({26'h0, alt_oe, pin_oe}, 32'h33);
    wr(pwm_pkg::OFF_RELOC, 8'h00);
    $display("Mode test done");
    // Sleep holds the count and pins; waking resumes from the held count.
    wr(pwm_pkg::OFF_TCFG, 8'h06);
    wr(pwm_pkg::OFF_CTRL, 8'h2C);
    measure(0, 1'b1, hi, per);
    repeat (70) @(posedge pclk);
    sleep_req <= 1'b1;
    repeat (8) @(posedge pclk);
    rd_chk(pwm_pkg::OFF_COUNT, 32'h1);
    repeat (200) @(posedge pclk);
    rd_chk(pwm_pkg::OFF_COUNT, 32'h1);
    sleep_req <= 1'b0;
    repeat (5) @(posedge pclk);
    rd_chk(pwm_pkg::OFF_COUNT, 32'h1);
    repeat (50) @(posedge pclk);
    rd_chk(pwm_pkg::OFF_COUNT, 32'h2);
    $display("Sleep test done");
    tally_and_finish();
  end
endmodule
